// file: rtl/tes_pkg.sv
package tes_pkg;
  typedef enum logic [3:0] {
    TES_STYLE_RSVD   = 4'b0000,
    TES_STYLE_LIN1   = 4'b0001,
    TES_STYLE_LIN2   = 4'b0010,
    TES_STYLE_LIN3   = 4'b0011,
    TES_STYLE_LUT    = 4'b0100,
    TES_STYLE_LUT_AC = 4'b0101,
    TES_STYLE_LUT_A  = 4'b0110
  } tes_style_e;

  typedef enum logic [1:0] {
    TES_ST_IDLE = 2'b00,
    TES_ST_FALL = 2'b01,
    TES_ST_HOLD = 2'b10,
    TES_ST_RISE = 2'b11
  } tes_state_e;
endpackage

// file: rtl/tes_ramp.sv
`timescale 1ns/1ns
`default_nettype none
`include "tes_regs.svh"
module tes_ramp (
  tes_shape_if.ramp sh
);
  // Curve tables, 4 tables of 9 breakpoints over the edge
  localparam logic [8:0] LUT [0:3][0:8] = '{
    '{9'h000, 9'h020, 9'h040, 9'h060, 9'h080, 9'h0A0, 9'h0C0, 9'h0E0, 9'h100},
    '{9'h000, 9'h008, 9'h020, 9'h048, 9'h080, 9'h0B8, 9'h0E0, 9'h0F8, 9'h100},
    '{9'h000, 9'h040, 9'h070, 9'h098, 9'h0B8, 9'h0D0, 9'h0E8, 9'h0F8, 9'h100},
    '{9'h000, 9'h008, 9'h018, 9'h030, 9'h048, 9'h068, 9'h090, 9'h0C0, 9'h100}
  };

  // Linear piece from (x0,y0) rising to y1 over 2**sh steps of f
  function automatic logic [8:0] seg(input logic [8:0] f, input logic [8:0] x0,
                                     input logic [8:0] y0, input logic [8:0] y1,
                                     input int sh);
    logic signed [19:0] p;
    p = ($signed({11'd0, f}) - $signed({11'd0, x0}))
      * ($signed({11'd0, y1}) - $signed({11'd0, y0}));
    p = (p >>> sh) + $signed({11'd0, y0});
    return p[8:0];
  endfunction

  logic [8:0]  g;
  logic [8:0]  g_adj;
  logic [8:0]  knee;
  logic [8:0]  k1;
  logic [8:0]  k2;
  logic [1:0]  ti;
  logic [2:0]  pi;
  logic [7:0]  sag;
  logic [17:0] boost;
  logic signed [18:0] lv;

  always_comb begin
    knee  = 9'(9'h080 + {2'd0, sh.tsel, 4'd0});
    k1    = 9'(9'h040 + {3'd0, sh.tsel, 3'd0});
    k2    = 9'(9'h0C0 + {3'd0, sh.tsel, 3'd0});
    ti    = sh.tsel[1:0];
    pi    = sh.frac[7:5];
    sag   = `TES_LEVEL_FULL - sh.supply;
    g     = `TES_FRAC_ONE;
    unique case (sh.style)
      tes_pkg::TES_STYLE_LIN1: g = sh.frac;
      tes_pkg::TES_STYLE_LIN2: begin
        if (sh.frac < 9'h080) g = seg(sh.frac, 9'h000, 9'h000, knee, 7);
        else g = seg(sh.frac, 9'h080, knee, `TES_FRAC_ONE, 7);
      end
      tes_pkg::TES_STYLE_LIN3: begin
        if (sh.frac < 9'h040) g = seg(sh.frac, 9'h000, 9'h000, k1, 6);
        else if (sh.frac < 9'h0C0) g = seg(sh.frac, 9'h040, k1, k2, 7);
        else g = seg(sh.frac, 9'h0C0, k2, `TES_FRAC_ONE, 6);
      end
      tes_pkg::TES_STYLE_LUT, tes_pkg::TES_STYLE_LUT_AC,
      tes_pkg::TES_STYLE_LUT_A: begin
        if (sh.frac[8]) g = `TES_FRAC_ONE;
        else g = seg(sh.frac, {1'b0, pi, 5'd0}, LUT[ti][pi],
                     LUT[ti][4'({1'b0, pi}) + 4'd1], 5);
      end
      // Reserved codes jump straight to the target level
      default: g = `TES_FRAC_ONE;
    endcase
    // Boost needs the finished curve value, so it follows the style decode
    boost = 18'(((18'h100 - {9'd0, g}) * {10'd0, sag}) >> 9);
    g_adj = g;
    if (sh.style == tes_pkg::TES_STYLE_LUT_AC ||
        sh.style == tes_pkg::TES_STYLE_LUT_A) begin
      g_adj = 9'(g + boost[8:0]);
      // Correction pulls the curve further ahead when the supply sags
      if (sh.style == tes_pkg::TES_STYLE_LUT_AC)
        g_adj = 9'(g_adj + {5'd0, sag[7:4]});
      if (g_adj > `TES_FRAC_ONE || g == `TES_FRAC_ONE) g_adj = `TES_FRAC_ONE;
    end
    lv = ($signed({11'd0, sh.to_lvl}) - $signed({11'd0, sh.from_lvl}))
       * $signed({10'd0, g_adj});
    lv = (lv >>> `TES_FRAC_SH) + $signed({11'd0, sh.from_lvl});
    sh.level = lv[7:0];
  end
endmodule // tes_ramp
`default_nettype wire

// file: rtl/tes_regs.svh
`ifndef TES_REGS_SVH
`define TES_REGS_SVH
// Register indices; byte address is four times the index
`define TES_IDX_KIND      10'h04D
`define TES_IDX_TIME      10'h04E
`define TES_IDX_COUNT     10'h04F
`define TES_IDX_RESID     10'h050
`define TES_IDX_STATUS    10'h051
// Field positions
`define TES_FALL_KIND_HI  7
`define TES_FALL_KIND_LO  4
`define TES_RISE_KIND_HI  3
`define TES_RISE_KIND_LO  0
`define TES_FALL_TIME_HI  6
`define TES_FALL_TIME_LO  4
`define TES_RISE_TIME_HI  2
`define TES_RISE_TIME_LO  0
`define TES_CNT_DBL_BIT   7
`define TES_CNT_HI        4
`define TES_CNT_LO        0
// Writable bit masks, reserved bits read zero
`define TES_TIME_MASK     8'h77
`define TES_COUNT_MASK    8'h9F
// Reset values
`define TES_KIND_RST      8'h00
`define TES_TIME_RST      8'h00
`define TES_COUNT_RST     8'h00
`define TES_RESID_RST     8'h00
// Amplitude levels
`define TES_LEVEL_FULL    8'hFF
`define TES_FRAC_ONE      9'h100
`define TES_FRAC_SH       8
`endif

// file: rtl/tes_shape_if.sv
`timescale 1ns/1ns
`default_nettype none
interface tes_shape_if;
  logic [3:0] style;
  logic [2:0] tsel;
  logic [8:0] frac;
  logic [7:0] from_lvl;
  logic [7:0] to_lvl;
  logic [7:0] supply;
  logic [7:0] level;
  modport ctrl (output style, output tsel, output frac, output from_lvl,
                output to_lvl, output supply, input level);
  modport ramp (input style, input tsel, input frac, input from_lvl,
                input to_lvl, input supply, output level);
endinterface
`default_nettype wire

// file: rtl/tes_shaper.sv
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "tes_regs.svh"
// Function
// - The falling-edge style comes from the upper nibble and the rising-edge style from the lower nibble of the edge kind register, decoded apart.
// - The rising-edge nibble uses the same style codes as the falling edge.
// - Code 1 gives one linear ramp and code 2 two linear ramps, computed without a table.
// - Code 3 gives three linear ramps, computed without a table.
// - Code 4 plays a table with no supply adaptation.
// - Code 5 plays a table adapted to the amplifier supply, with correction.
// - Code 6 plays a table adapted to the amplifier supply, without correction.
// - Time bits 6 to 4 are the falling-edge time constant for codes 2 and 3; code 1 ignores them.
// - Time bits 2 to 0 are the rising-edge time constant for codes 2 and 3; code 1 ignores them; bits 7 and 3 are reserved.
// - For codes 4 to 6 each 3-bit time field picks table 0 to 3 for its edge.
// - With the doubling bit clear each transition state lasts one carrier cycle, for both edges.
// - With the doubling bit set each transition state lasts two carrier cycles.
// - Count bits 4 to 0 give the number of transition states of both edges; bits 6 to 5 are reserved.
module tes_shaper #(
  parameter int ADDR_W      = 12,
  parameter int CARRIER_DIV = 2
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              mod_req,
  input  wire logic [7:0]        pa_supply_level,
  output logic      [7:0]        carrier_amp,
  output logic                   edge_busy
);
  localparam int DIV_W = (CARRIER_DIV > 1) ? $clog2(CARRIER_DIV) : 1;

  function automatic logic idx_hit(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
    return (a[ADDR_W-1:2] == (ADDR_W-2)'(idx)) && (a[1:0] == 2'b00);
  endfunction

  // Register file
  logic [7:0] kind_q;
  logic [7:0] time_q;
  logic [7:0] count_q;
  logic [7:0] resid_q;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic        mapped;
  logic        wr_en;

  // Synchroniser for the supply level, which comes from the analog side
  logic [7:0] sup_s1_q;
  logic [7:0] sup_s2_q;
  logic [7:0] sup_s3_q;
  logic [7:0] supply_q;

  // Sequencer
  tes_pkg::tes_state_e state_q;
  logic [DIV_W-1:0] div_q;
  logic             carrier_tick;
  logic             half_q;
  logic             step_tick;
  logic [4:0]       step_q;
  logic [7:0]       amp_q;
  logic [7:0]       snap_kind_q;
  logic [7:0]       snap_time_q;
  logic [7:0]       snap_count_q;
  logic [7:0]       snap_resid_q;
  logic             last_step;
  logic [8:0]       frac;
  logic             falling;

  tes_shape_if shape ();

  tes_ramp u_ramp (
    .sh (shape.ramp)
  );

  // APB decode
  always_comb begin
    mapped = idx_hit(paddr, `TES_IDX_KIND) || idx_hit(paddr, `TES_IDX_TIME) ||
             idx_hit(paddr, `TES_IDX_COUNT) || idx_hit(paddr, `TES_IDX_RESID) ||
             idx_hit(paddr, `TES_IDX_STATUS);
    wr_en  = psel && penable && pwrite && mapped && pstrb[0];
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = rdata_q;

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (idx_hit(paddr, `TES_IDX_KIND)) rdata_d[7:0] = kind_q;
    else if (idx_hit(paddr, `TES_IDX_TIME)) rdata_d[7:0] = time_q;
    else if (idx_hit(paddr, `TES_IDX_COUNT)) rdata_d[7:0] = count_q;
    else if (idx_hit(paddr, `TES_IDX_RESID)) rdata_d[7:0] = resid_q;
    else if (idx_hit(paddr, `TES_IDX_STATUS)) begin
      rdata_d[0]     = edge_busy;
      rdata_d[2:1]   = state_q;
      rdata_d[12:8]  = step_q;
      rdata_d[23:16] = amp_q;
      rdata_d[31:24] = supply_q;
    end
  end

  // Read data is caught in the setup cycle so it stands through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kind_q  <= `TES_KIND_RST;
      time_q  <= `TES_TIME_RST;
      count_q <= `TES_COUNT_RST;
      resid_q <= `TES_RESID_RST;
    end else if (wr_en) begin
      if (idx_hit(paddr, `TES_IDX_KIND)) kind_q <= pwdata[7:0];
      if (idx_hit(paddr, `TES_IDX_TIME)) time_q <= pwdata[7:0] & `TES_TIME_MASK;
      if (idx_hit(paddr, `TES_IDX_COUNT)) count_q <= pwdata[7:0] & `TES_COUNT_MASK;
      if (idx_hit(paddr, `TES_IDX_RESID)) resid_q <= pwdata[7:0];
    end
  end

  // A new value counts only once the second and third stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sup_s1_q <= 8'h00;
      sup_s2_q <= 8'h00;
      sup_s3_q <= 8'h00;
      supply_q <= 8'h00;
    end else begin
      sup_s1_q <= pa_supply_level;
      sup_s2_q <= sup_s1_q;
      sup_s3_q <= sup_s2_q;
      if (sup_s2_q == sup_s3_q) supply_q <= sup_s3_q;
    end
  end

  // Carrier cycle enable, restarted between edges so every edge has the same length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
    end else if (state_q == tes_pkg::TES_ST_IDLE || state_q == tes_pkg::TES_ST_HOLD) begin
      div_q <= '0;
    end else if (div_q == DIV_W'(CARRIER_DIV - 1)) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  assign carrier_tick = (div_q == DIV_W'(CARRIER_DIV - 1));

  // With doubling each state waits for every second carrier cycle
  assign step_tick = carrier_tick &&
                     (!snap_count_q[`TES_CNT_DBL_BIT] || half_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_q <= 1'b0;
    end else if (state_q == tes_pkg::TES_ST_IDLE || state_q == tes_pkg::TES_ST_HOLD) begin
      half_q <= 1'b0;
    end else if (carrier_tick) begin
      half_q <= !half_q;
    end
  end

  // Settings are frozen at the start of an edge; a write mid-edge would tear the shape
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_kind_q  <= `TES_KIND_RST;
      snap_time_q  <= `TES_TIME_RST;
      snap_count_q <= `TES_COUNT_RST;
      snap_resid_q <= `TES_RESID_RST;
    end else if ((state_q == tes_pkg::TES_ST_IDLE && mod_req) ||
                 (state_q == tes_pkg::TES_ST_HOLD && !mod_req)) begin
      snap_kind_q  <= kind_q;
      snap_time_q  <= time_q;
      snap_count_q <= count_q;
      snap_resid_q <= resid_q;
    end
  end

  assign last_step = ({1'b0, step_q} + 6'd1 >=
                      {1'b0, snap_count_q[`TES_CNT_HI:`TES_CNT_LO]});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= tes_pkg::TES_ST_IDLE;
      step_q  <= 5'd0;
    end else begin
      unique case (state_q)
        tes_pkg::TES_ST_IDLE: begin
          step_q <= 5'd0;
          if (mod_req) state_q <= tes_pkg::TES_ST_FALL;
        end
        tes_pkg::TES_ST_FALL: begin
          if (step_tick) begin
            if (last_step) begin
              state_q <= tes_pkg::TES_ST_HOLD;
              step_q  <= 5'd0;
            end else begin
              step_q <= step_q + 5'd1;
            end
          end
        end
        tes_pkg::TES_ST_HOLD: begin
          step_q <= 5'd0;
          if (!mod_req) state_q <= tes_pkg::TES_ST_RISE;
        end
        tes_pkg::TES_ST_RISE: begin
          if (step_tick) begin
            if (last_step) begin
              state_q <= tes_pkg::TES_ST_IDLE;
              step_q  <= 5'd0;
            end else begin
              step_q <= step_q + 5'd1;
            end
          end
        end
      endcase
    end
  end

  // Fraction of the edge covered after this step, 256 is the whole edge
  always_comb begin
    frac = `TES_FRAC_ONE;
    if (!last_step) begin
      frac = 9'((({1'b0, step_q} + 6'd1) * 14'd256) /
                {9'd0, snap_count_q[`TES_CNT_HI:`TES_CNT_LO]});
    end
  end

  assign falling = (state_q == tes_pkg::TES_ST_FALL);

  always_comb begin
    shape.frac     = frac;
    shape.supply   = supply_q;
    shape.from_lvl = falling ? `TES_LEVEL_FULL : snap_resid_q;
    shape.to_lvl   = falling ? snap_resid_q : `TES_LEVEL_FULL;
    if (falling) begin
      shape.style = snap_kind_q[`TES_FALL_KIND_HI:`TES_FALL_KIND_LO];
      shape.tsel  = snap_time_q[`TES_FALL_TIME_HI:`TES_FALL_TIME_LO];
    end else begin
      shape.style = snap_kind_q[`TES_RISE_KIND_HI:`TES_RISE_KIND_LO];
      shape.tsel  = snap_time_q[`TES_RISE_TIME_HI:`TES_RISE_TIME_LO];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_q <= `TES_LEVEL_FULL;
    end else if ((state_q == tes_pkg::TES_ST_FALL || state_q == tes_pkg::TES_ST_RISE)
                 && step_tick) begin
      amp_q <= shape.level;
    end else if (state_q == tes_pkg::TES_ST_IDLE) begin
      amp_q <= `TES_LEVEL_FULL;
    end else if (state_q == tes_pkg::TES_ST_HOLD) begin
      amp_q <= snap_resid_q;
    end
  end

  assign carrier_amp = amp_q;
  assign edge_busy   = (state_q == tes_pkg::TES_ST_FALL) ||
                       (state_q == tes_pkg::TES_ST_RISE);
endmodule // tes_shaper
`default_nettype wire

// file: tb/tes_shaper_assertions.sv
`timescale 1ns/1ns
`default_nettype none
`include "tes_regs.svh"
module tes_shaper_assertions #(
  parameter int ADDR_W      = 12,
  parameter int CARRIER_DIV = 2
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              mod_req,
  input wire logic [7:0]        pa_supply_level,
  input wire logic [7:0]        carrier_amp,
  input wire logic              edge_busy
);
  logic [7:0]  cnt_q;
  logic [7:0]  res_q;
  logic [7:0]  snap_q;
  logic [15:0] run_q;
  logic        hold_q;
  logic        acc;
  logic [9:0]  idx;
  logic [15:0] exp_len;
  assign acc = psel && penable;
  assign idx = 10'(paddr >> 2);
  assign exp_len = 16'((snap_q[4:0] == 5'h00 ? 1 : int'(snap_q[4:0])) * CARRIER_DIV
                       * (snap_q[7] ? 2 : 1));
  // Shadow the settings from bus writes, so no internal probe is needed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= 8'h00;
      res_q  <= 8'h00;
      snap_q <= 8'h00;
      run_q  <= 16'h0000;
      hold_q <= 1'b0;
    end else begin
      if (acc && pwrite && pstrb[0] && idx == `TES_IDX_COUNT) cnt_q <= pwdata[7:0];
      if (acc && pwrite && pstrb[0] && idx == `TES_IDX_RESID) res_q <= pwdata[7:0];
      if (edge_busy && run_q == 16'h0000) snap_q <= cnt_q;
      run_q <= edge_busy ? run_q + 16'h0001 : 16'h0000;
      if (!edge_busy && run_q != 16'h0000) hold_q <= !hold_q;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_edge_end;
    !edge_busy && run_q != 16'h0000;
  endsequence
  sequence s_read(logic [9:0] i);
    acc && !pwrite && paddr[1:0] == 2'b00 && idx == i;
  endsequence
  property p_len_single;
    s_edge_end |-> snap_q[7] || run_q == exp_len;
  endproperty
  a_len_single: assert property (p_len_single) else $error("edge length wrong");
  property p_len_double;
    s_edge_end |-> !snap_q[7] || run_q == exp_len;
  endproperty
  a_len_double: assert property (p_len_double) else $error("doubled edge length wrong");
  property p_fall_level;
    s_edge_end |-> hold_q || carrier_amp == res_q;
  endproperty
  a_fall_level: assert property (p_fall_level) else $error("falling edge end level");
  property p_rise_level;
    s_edge_end |-> !hold_q || carrier_amp == 8'hff;
  endproperty
  a_rise_level: assert property (p_rise_level) else $error("rising edge end level");
  property p_idle_full;
    !edge_busy && run_q == 16'h0000 && !hold_q |-> carrier_amp == 8'hff;
  endproperty
  a_idle_full: assert property (p_idle_full) else $error("idle carrier not full");
  property p_time_rsvd;
    s_read(`TES_IDX_TIME) |-> (prdata & 32'hffff_ff88) == 32'h0000_0000;
  endproperty
  a_time_rsvd: assert property (p_time_rsvd) else $error("time reserved bits set");
  property p_cnt_rsvd;
    s_read(`TES_IDX_COUNT) |-> (prdata & 32'hffff_ff60) == 32'h0000_0000;
  endproperty
  a_cnt_rsvd: assert property (p_cnt_rsvd) else $error("count reserved bits set");
  property p_slverr;
    acc && !(paddr[1:0] == 2'b00 && idx >= `TES_IDX_KIND && idx <= `TES_IDX_STATUS)
      |-> pslverr;
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped access not refused");
endmodule // tes_shaper_assertions
bind tes_shaper tes_shaper_assertions #(.ADDR_W(ADDR_W), .CARRIER_DIV(CARRIER_DIV))
  i_tes_shaper_assertions (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .mod_req(mod_req), .pa_supply_level(pa_supply_level),
  .carrier_amp(carrier_amp), .edge_busy(edge_busy));
`default_nettype wire

// file: tb/test_tx_edge_shaping_cfg.sv
`timescale 1ns/1ns
`default_nettype none
`include "tes_regs.svh"
module test_tx_edge_shaping_cfg;
  localparam int DIV = 2;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        mod_req;
  logic [7:0]  pa_supply_level;
  logic [7:0]  carrier_amp;
  logic        edge_busy;
  logic [32:0] exp_q[$];
  logic [15:0] run = 16'h0000;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  tes_shaper #(.ADDR_W(12), .CARRIER_DIV(DIV)) i_tes_shaper (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mod_req(mod_req), .pa_supply_level(pa_supply_level),
    .carrier_amp(carrier_amp), .edge_busy(edge_busy));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [32:0] got);
    logic [32:0] exp;
    cmp_count++;
    exp = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1_ffff_ffff;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected result at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Reads and edge completions both land in the same queue of notes
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) check({pslverr, prdata});
    if (edge_busy === 1'b1) begin
      run <= run + 16'h0001;
    end else if (run != 16'h0000) begin
      check({9'h000, run, carrier_amp});
      run <= 16'h0000;
    end
  end

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  function automatic logic [11:0] ad(input logic [9:0] i);
    return {i, 2'b00};
  endfunction

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
  endtask

  task automatic wait_busy(input logic lvl);
    int i;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (edge_busy !== lvl && i < 500);
  endtask

  // Early release checks that a request change mid-edge is held off
  task automatic edge_run(input logic [3:0] code, input logic [4:0] n, input logic dbl,
                          input logic early);
    logic [7:0]  res;
    logic [15:0] len;
    res = 8'($urandom());
    len = 16'(n) * 16'(DIV) * (dbl ? 16'h0002 : 16'h0001);
    apb(1'b1, ad(`TES_IDX_KIND), {24'h00_0000, code, 4'h7 - code}, 4'hf);
    apb(1'b1, ad(`TES_IDX_TIME), $urandom(), 4'hf);
    apb(1'b1, ad(`TES_IDX_COUNT), {24'h00_0000, dbl, 2'b11, n}, 4'hf);
    apb(1'b1, ad(`TES_IDX_RESID), {24'h00_0000, res}, 4'hf);
    exp_q.push_back({9'h000, len, res});
    exp_q.push_back({9'h000, len, 8'hff});
    @(posedge pclk);
    mod_req <= 1'b1;
    wait_busy(1'b1);
    if (early) mod_req <= 1'b0;
    wait_busy(1'b0);
    mod_req <= 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    mod_req = 1'b0;
    void'($urandom(32'hfe54_555b));
    pa_supply_level = 8'($urandom());
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) rd(ad(10'(`TES_IDX_KIND + i)), 33'h0_0000_0000);
    rd(ad(`TES_IDX_STATUS), {1'b0, pa_supply_level, 8'hff, 16'h0000});
    apb(1'b1, ad(`TES_IDX_TIME), 32'hffff_ffff, 4'hf);
    rd(ad(`TES_IDX_TIME), 33'h0_0000_0077);
    apb(1'b1, ad(`TES_IDX_COUNT), 32'hffff_ffff, 4'hf);
    rd(ad(`TES_IDX_COUNT), 33'h0_0000_009f);
    apb(1'b1, ad(`TES_IDX_COUNT), 32'h0000_0000, 4'h0);
    rd(ad(`TES_IDX_COUNT), 33'h0_0000_009f);
    rd(12'h148, 33'h1_0000_0000);
    for (int c = 1; c <= 6; c++) begin
      edge_run(4'(c), (c == 6) ? 5'h1f : 5'(c * 2 - 1), c[0], !c[0]);
    end
    edge_run(4'h0, 5'h02, 1'b1, 1'b0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(ad(`TES_IDX_COUNT), 33'h0_0000_0000);
    repeat (4) @(posedge pclk);
    stop_test();
  end
endmodule // test_tx_edge_shaping_cfg
`default_nettype wire
